// >>> hw/slave_write_seq.sv
// Slave-port write sequencer: fixed, peripheral-paced, setup and hold timing.
// Assumes the request side and the slave's waitrequest share this clock.
`timescale 1ns/1ps

// Functional notes
// - Fixed wait count adds exactly that many cycles to every write on a port that is not peripheral-paced.
// - Address, data, lanes, select appear in first cycle; all outputs stay unchanged through wait states.
// - Select and master wait released on the transfer's final edge; strobe with them only when hold is zero.
// - On a paced port, sampled waitrequest high makes the next cycle a held wait state.
// - After waitrequest falls the transfer ends next edge; next may follow.
// - No time-out on peripheral wait; stay stalled with the master.
// - Setup and hold ignored on a peripheral-paced port.
// - Setup count M delays write strobe M cycles after address presented.
// - Hold count N keeps address, data, lanes, select N cycles after strobe.
// - Chipselect spans setup and hold, not shifted by them.
// - Transfer length on a port that is not peripheral-paced is setup plus waits plus hold plus one.
// - Setup and hold are configured independently.
// - Timing applied here; master only sees its waitrequest.
// - One setup, one hold: strobe low only in the middle cycle.
// - Registered address, data, lanes, strobe, and chipselect set from address decode.
module slave_write_seq
   import wr_seq_pkg::*;
(
   // Clock, reset, enable
   input  wire logic               I_SYS_CLK,
   input  wire logic               I_SYS_RST,
   input  wire logic               I_CLK_EN,
   // Timing configuration
   input  wire logic [CNT_W-1:0]   I_SETUP_CYCLES,
   input  wire logic [CNT_W-1:0]   I_WAIT_CYCLES,
   input  wire logic [CNT_W-1:0]   I_HOLD_CYCLES,
   input  wire logic               I_PERIPH_PACED,
   // Address window of this slave port
   input  wire logic [ADDR_W-1:0]  I_SEL_BASE,
   input  wire logic [ADDR_W-1:0]  I_SEL_MASK,
   // Master-side request
   input  wire logic               I_REQ_WRITE,
   input  wire logic [ADDR_W-1:0]  I_REQ_ADDR,
   input  wire logic [DATA_W-1:0]  I_REQ_DATA,
   input  wire logic [LANES_W-1:0] I_REQ_LANES_N,
   output logic                    O_REQ_WAIT,
   output logic                    O_REQ_DONE,
   // Slave port
   output logic [ADDR_W-1:0]       O_ADDRESS,
   output logic [DATA_W-1:0]       O_WRITEDATA,
   output logic [LANES_W-1:0]      O_BYTE_LANE_ENABLES_LOW,
   output logic                    O_WRITE_N,
   output logic                    O_CHIPSELECT,
   input  wire logic               I_WAITREQUEST,
   // Status
   output logic                    O_BUSY
);

   wr_state_t          state;
   wr_state_t          next_state;
   logic [CNT_W-1:0]   cnt;
   logic [CNT_W-1:0]   next_cnt;
   logic [CNT_W-1:0]   hold_len;
   logic [CNT_W-1:0]   next_hold_len;
   logic               paced;
   logic               next_paced;
   logic [ADDR_W-1:0]  addr;
   logic [ADDR_W-1:0]  next_addr;
   logic [DATA_W-1:0]  data;
   logic [DATA_W-1:0]  next_data;
   logic [LANES_W-1:0] lanes;
   logic [LANES_W-1:0] next_lanes;
   logic               wr_n;
   logic               next_wr_n;
   logic               sel;
   logic               next_sel;
   logic               wait_o;
   logic               next_wait_o;
   logic               done;
   logic               next_done;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] b,
                                input logic [ADDR_W-1:0] m);
      hit = ((a ^ b) & m) == '0;
   endfunction : hit

   // Fixed waits count only on a port that does not pace itself
   function automatic logic fixed_waits(input logic             pc,
                                        input logic [CNT_W-1:0] w);
      fixed_waits = !pc && (w != CNT_ZERO);
   endfunction : fixed_waits

   // Waitrequest is same-clock slave logic and is read as is: a synchroniser
   // would let the stall land two cycles after the edge the slave relies on.

   // A transfer always ends in idle for one cycle, so chipselect drops
   // between back-to-back writes and the slave sees each one apart.
   always_comb begin
      next_state    = state;
      next_cnt      = dec(cnt);
      next_hold_len = hold_len;
      next_paced    = paced;
      next_addr     = addr;
      next_data     = data;
      next_lanes    = lanes;
      next_wr_n     = wr_n;
      next_sel      = sel;
      next_wait_o   = wait_o;
      next_done     = 1'b0;
      case (state)
         ST_IDLE: begin
            next_wr_n   = WSTROBE_IDLE;
            next_sel    = 1'b0;
            next_wait_o = 1'b0;
            if (I_REQ_WRITE && hit(I_REQ_ADDR, I_SEL_BASE, I_SEL_MASK)) begin
               next_addr   = I_REQ_ADDR;
               next_data   = I_REQ_DATA;
               next_lanes  = I_REQ_LANES_N;
               next_sel    = 1'b1;
               next_paced  = I_PERIPH_PACED;
               next_wait_o = 1'b1;
               // Paced port drops setup and hold
               next_hold_len = I_PERIPH_PACED ? CNT_ZERO : I_HOLD_CYCLES;
               if (!I_PERIPH_PACED && I_SETUP_CYCLES != CNT_ZERO) begin
                  next_state = ST_SETUP;
                  next_cnt   = I_SETUP_CYCLES;
               end else begin
                  next_wr_n = 1'b0;
                  if (fixed_waits(I_PERIPH_PACED, I_WAIT_CYCLES)) begin
                     next_state = ST_WAIT;
                     next_cnt   = I_WAIT_CYCLES;
                  end else begin
                     next_state = ST_CAPT;
                  end
               end
            end
         end
         ST_SETUP: begin
            if (cnt == CNT_ONE) begin
               next_wr_n = 1'b0;
               if (fixed_waits(paced, I_WAIT_CYCLES)) begin
                  next_state = ST_WAIT;
                  next_cnt   = I_WAIT_CYCLES;
               end else begin
                  next_state = ST_CAPT;
               end
            end
         end
         ST_WAIT: begin
            if (cnt == CNT_ONE) begin
               next_state = ST_CAPT;
            end
         end
         ST_CAPT: begin
            // On a paced port, sampled waitrequest holds everything; no time-out by design
            if (paced && I_WAITREQUEST) begin
               next_state = ST_CAPT;
            end else if (hold_len != CNT_ZERO) begin
               next_state = ST_HOLD;
               next_cnt   = hold_len;
               next_wr_n  = WSTROBE_IDLE;
            end else begin
               next_state  = ST_IDLE;
               next_wr_n   = WSTROBE_IDLE;
               next_sel    = 1'b0;
               next_wait_o = 1'b0;
               next_done   = 1'b1;
            end
         end
         ST_HOLD: begin
            if (cnt == CNT_ONE) begin
               next_state  = ST_IDLE;
               next_sel    = 1'b0;
               next_wait_o = 1'b0;
               next_done   = 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_wr_n  = WSTROBE_IDLE;
            next_sel   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
         state    <= ST_IDLE;
         cnt      <= CNT_ZERO;
         hold_len <= CNT_ZERO;
         paced    <= 1'b0;
         addr     <= ADDR_RST;
         data     <= DATA_RST;
         lanes    <= LANES_RST;
         wr_n     <= WSTROBE_IDLE;
         sel      <= 1'b0;
         wait_o   <= 1'b0;
         done     <= 1'b0;
      end else if (I_CLK_EN) begin
         state    <= next_state;
         cnt      <= next_cnt;
         hold_len <= next_hold_len;
         paced    <= next_paced;
         addr     <= next_addr;
         data     <= next_data;
         lanes    <= next_lanes;
         wr_n     <= next_wr_n;
         sel      <= next_sel;
         wait_o   <= next_wait_o;
         done     <= next_done;
      end
   end

   // Ports are plain register copies; no logic between flop and pin
   assign O_ADDRESS               = addr;
   assign O_WRITEDATA             = data;
   assign O_BYTE_LANE_ENABLES_LOW = lanes;
   assign O_WRITE_N               = wr_n;
   assign O_CHIPSELECT            = sel;
   assign O_REQ_WAIT              = wait_o;
   assign O_REQ_DONE              = done;
   assign O_BUSY                  = wait_o;
endmodule : slave_write_seq

// >>> pkg/wr_seq_pkg.sv
// Constants for the slave-side write sequencer.
// Assumes one system clock; timing options arrive as configuration ports.
package wr_seq_pkg;
   localparam int ADDR_W  = 32;
   localparam int DATA_W  = 32;
   localparam int LANES_W = DATA_W / 8;
   localparam int CNT_W   = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
   localparam logic WSTROBE_IDLE = 1'b1;
   localparam logic [ADDR_W-1:0]  ADDR_RST  = 32'h0000_0000;
   localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
   localparam logic [LANES_W-1:0] LANES_RST = 4'hf;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_WAIT  = 3'b011,
      ST_CAPT  = 3'b010,
      ST_HOLD  = 3'b110
   } wr_state_t;

   // Next count value of a phase counter
   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      dec = (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
   endfunction : dec
endpackage : wr_seq_pkg

// >>> sim/slave_write_seq_asserts.sv
// Port checker for the slave write sequencer.
// Assumes timing inputs stay steady during a transfer.
`timescale 1ns/1ps
module slave_write_seq_asserts
   import wr_seq_pkg::*;
(
   input wire logic I_SYS_CLK, I_SYS_RST, I_PERIPH_PACED, I_WAITREQUEST,
   input wire logic O_REQ_DONE, O_WRITE_N, O_CHIPSELECT,
   input wire logic [CNT_W-1:0] I_SETUP_CYCLES, I_WAIT_CYCLES, I_HOLD_CYCLES,
   input wire logic [ADDR_W-1:0] O_ADDRESS,
   input wire logic [DATA_W-1:0] O_WRITEDATA,
   input wire logic [LANES_W-1:0] O_BYTE_LANE_ENABLES_LOW
);
   logic [9:0] pos, next_pos, m, sw;
   assign m = 10'(I_SETUP_CYCLES);
   assign sw = m + 10'(I_WAIT_CYCLES);
   // Cycle index inside a transfer
   always_comb next_pos = O_CHIPSELECT ? pos + 10'h001 : 10'h000;
   always_ff @(posedge I_SYS_CLK) pos <= I_SYS_RST ? 10'h000 : next_pos;
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_SYS_RST);
   sequence s_stall; I_WAITREQUEST [*3] ##0 (O_CHIPSELECT && I_PERIPH_PACED); endsequence
   sequence s_end; $fell(O_CHIPSELECT) ##0 !I_PERIPH_PACED; endsequence
   a_idle_strobe: assert property (!O_CHIPSELECT |-> O_WRITE_N)
      else $error("idle strobe");
   a_fields_held: assert property (O_CHIPSELECT && $past(O_CHIPSELECT) |->
      $stable(O_ADDRESS) && $stable(O_WRITEDATA) && $stable(O_BYTE_LANE_ENABLES_LOW))
      else $error("fields moved");
   a_strobe_phase: assert property (O_CHIPSELECT && !I_PERIPH_PACED |->
      O_WRITE_N == !(pos >= m && pos <= sw)) else $error("strobe window");
   a_length_exact: assert property (s_end |-> $past(pos) == sw + 10'(I_HOLD_CYCLES))
      else $error("length");
   a_paced_strobe: assert property (O_CHIPSELECT && I_PERIPH_PACED |-> !O_WRITE_N)
      else $error("paced setup");
   a_stall_holds: assert property (s_stall |=> O_CHIPSELECT && !O_WRITE_N)
      else $error("stall lost");
   a_release_end: assert property ($fell(I_WAITREQUEST) && O_CHIPSELECT && I_PERIPH_PACED
      |=> !O_CHIPSELECT) else $error("no end");
   a_done_after: assert property ($fell(O_CHIPSELECT) |-> O_REQ_DONE)
      else $error("no done");
endmodule : slave_write_seq_asserts

// >>> sim/slave_model.sv
// Slave peripheral model: captures writes, may stall.
// Assumes chipselect drops between transfers.
`timescale 1ns/1ps
module slave_model
   import wr_seq_pkg::*;
(
   input wire logic clk, cs, write_n,
   input wire logic [DATA_W-1:0] data,
   input wire logic [7:0] stall,
   output logic waitreq,
   output logic [DATA_W-1:0] cap_data
);
   logic [7:0] cnt = 8'h00;
   logic tog = 1'b0;
   // Deselected: toggle so a stale level never reads as a stall
   assign waitreq = cs ? (!write_n && cnt < stall) : tog;
   always @(posedge clk) begin
      tog <= ~tog;
      cnt <= cs ? cnt + 8'h01 : 8'h00;
      if (cs && !write_n && !waitreq) cap_data <= data;
   end
endmodule : slave_model

// >>> sim/slave_write_seq_bench.sv
// Bench for the slave write sequencer: one write per timing setup.
// Assumes a request is taken on the edge after it is raised.
`timescale 1ns/1ps
module slave_write_seq_bench;
   import wr_seq_pkg::*;
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, paced = 1'b0, wn, cs, done, wr, mwait, busy;
   logic [CNT_W-1:0] su = 8'h00, ws = 8'h00, ho = 8'h00, stall = 8'h00;
   logic [ADDR_W-1:0] addr = 32'h0000_0000, o_addr;
   logic [DATA_W-1:0] data = 32'h0000_0000, o_data, c_data;
   logic [LANES_W-1:0] lanes = 4'hf, o_lanes;
   logic [19:0] tbl [10] = '{20'h00000, 20'h01000, 20'h10100, 20'h23200, 20'h00200,
      20'h30000, 20'h05000, 20'h00010, 20'h00016, 20'h22213};
   int bad_count = 0, compares = 0, len, wlen, blen, exp_len;
   slave_write_seq dut_u (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'b1),
      .I_SETUP_CYCLES(su), .I_WAIT_CYCLES(ws), .I_HOLD_CYCLES(ho), .I_PERIPH_PACED(paced),
      .I_SEL_BASE(32'h4000_0000), .I_SEL_MASK(32'hf000_0000), .I_REQ_WRITE(req),
      .I_REQ_ADDR(addr), .I_REQ_DATA(data), .I_REQ_LANES_N(lanes), .O_REQ_WAIT(mwait),
      .O_REQ_DONE(done), .O_ADDRESS(o_addr), .O_WRITEDATA(o_data), .O_BUSY(busy),
      .O_BYTE_LANE_ENABLES_LOW(o_lanes), .O_WRITE_N(wn), .O_CHIPSELECT(cs), .I_WAITREQUEST(wr));
   slave_model sm_u (.clk(clk), .cs(cs), .write_n(wn), .data(o_data), .stall(stall),
      .waitreq(wr), .cap_data(c_data));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   // One-cycle request, then count cycles on the settled falling edge
   task automatic xfer(input logic [ADDR_W-1:0] a);
      int n;
      n = 0;
      len = 0;
      wlen = 0;
      blen = 0;
      @(posedge clk);
      req <= 1'b1;
      addr <= a;
      data <= ~a;
      lanes <= a[7:4];
      @(posedge clk);
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
         len += int'(cs === 1'b1);
         wlen += int'(mwait === 1'b1);
         blen += int'(busy === 1'b1);
      end while (done !== 1'b1 && n < 100);
   endtask : xfer
   initial forever #4 clk = ~clk;
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         su <= 8'(tbl[i][19:16]);
         ws <= 8'(tbl[i][15:12]);
         ho <= 8'(tbl[i][11:8]);
         paced <= tbl[i][4];
         stall <= 8'(tbl[i][3:0]);
         xfer(32'h4000_0000 + 32'(i * 16));
         // Paced port ignores setup, hold and fixed waits
         exp_len = tbl[i][4] ? 32'(stall) + 1 : 32'(su) + 32'(ws) + 32'(ho) + 1;
         check("done", 32'(done), 32'h1);
         if (tbl[i][4]) check("paced length", 32'(len), 32'(exp_len));
         else check("length", 32'(len), 32'(exp_len));
         check("master wait", 32'(wlen), 32'(exp_len));
         check("busy", 32'(blen), 32'(exp_len));
         check("address", o_addr, addr);
         check("lanes", 32'(o_lanes), 32'(lanes));
         check("captured", c_data, data);
      end
      xfer(32'h5000_0000);
      check("refused", 32'(len), 32'h0);
      check("refused wait", 32'(wlen), 32'h0);
      wrap_up();
   end
endmodule : slave_write_seq_bench
bind slave_write_seq slave_write_seq_asserts chk_u (.I_SYS_CLK, .I_SYS_RST, .I_PERIPH_PACED,
   .I_WAITREQUEST, .O_REQ_DONE, .O_WRITE_N, .O_CHIPSELECT, .I_SETUP_CYCLES, .I_WAIT_CYCLES,
   .I_HOLD_CYCLES, .O_ADDRESS, .O_WRITEDATA, .O_BYTE_LANE_ENABLES_LOW);
